// ---- common/rtcit_pkg.sv ----
// Shared constants and types of the rtc i2c target register port
//------------------------------------------------------------------
// Function
// R1: No chip select; address byte selects
// R2: Foreign address leaves SDA released
// R3: Address 0110010 in bits 7..1, R/W bit 0
// R4: SCL and SDA driven open-drain only
// R5: Write: acknowledge address and pointer bytes
// R6: Store data at pointer, acknowledge, increment
// R7: Controller sends any bytes, ends with STOP
// R8: Pointer write, repeated START, then read
// R9: Read from pointer, incrementing per byte
// R10: High acknowledge ends read; release SDA
// R11: Bare read starts after last access
// R12: MSB first, SDA moves while SCL low
// R13: START/STOP by SDA edge, SCL high
// R14: Whole eight-bit bytes, unlimited count
// R15: Transaction finishes within 0.95 seconds; the port has no timeout and can stretch SCL without bound
//------------------------------------------------------------------
package rtcit_pkg;
   localparam logic [6:0] TGT_ADDR  = 7'h32;
   localparam int         REG_DEPTH = 256;
   localparam logic [3:0] RX_BITS   = 4'h8;
   localparam logic [3:0] TX_LAST   = 4'h7;
   localparam logic [3:0] BIT_STEP  = 4'h1;
   localparam logic [7:0] PTR_STEP  = 8'h01;
   localparam logic       RW_READ   = 1'h1;

   typedef enum logic [2:0] {
      RTCIT_IDLE = 3'h0,
      RTCIT_RX   = 3'h1,
      RTCIT_WAIT = 3'h3,
      RTCIT_RACK = 3'h2,
      RTCIT_TX   = 3'h6,
      RTCIT_TACK = 3'h7
   } rtcit_state_t;

   typedef enum logic [1:0] {
      RTCIT_PH_ADDR = 2'h0,
      RTCIT_PH_PTR  = 2'h1,
      RTCIT_PH_DATA = 2'h2,
      RTCIT_PH_READ = 2'h3
   } rtcit_phase_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } rtcit_wr_t;
endpackage

// ---- common/rtcit_buf_if.sv ----
// Handshake bundle between the write-event source and its two-entry buffer
interface rtcit_buf_if;
   logic                valid_in;
   logic                ready_in;
   rtcit_pkg::rtcit_wr_t data_in;
   logic                valid_out;
   logic                ready_out;
   rtcit_pkg::rtcit_wr_t data_out;

   modport core (output valid_in, data_in, ready_out, input ready_in, valid_out, data_out);
   modport fifo (input valid_in, data_in, ready_out, output ready_in, valid_out, data_out);
endinterface

// ---- src/rtcit_buf.sv ----
// Two-entry register buffer for received register writes
module rtcit_buf (
   input wire logic clk,       // Core clock
   input wire logic rst,       // Synchronous reset, high
   rtcit_buf_if.fifo bi        // Fill and drain sides
);
   typedef struct packed {
      rtcit_pkg::rtcit_wr_t head;
      rtcit_pkg::rtcit_wr_t tail;
      logic                head_v;
      logic                tail_v;
   } rtcit_buf_st_t;

   rtcit_buf_st_t st_r;
   rtcit_buf_st_t st_nxt;
   logic          push;
   logic          pop;

   assign push         = bi.valid_in & ~st_r.tail_v;
   assign pop          = st_r.head_v & bi.ready_out;
   // Ready and valid are plain flops, so neither side sees a combinational path
   assign bi.ready_in  = ~st_r.tail_v;
   assign bi.valid_out = st_r.head_v;
   assign bi.data_out  = st_r.head;

   always_comb begin
      st_nxt = st_r;
      if (pop) begin
         if (st_r.tail_v) begin
            st_nxt.head = st_r.tail;
         end else begin
            st_nxt.head = bi.data_in;
         end
         st_nxt.head_v = st_r.tail_v | push;
         st_nxt.tail_v = 1'b0;
      end else if (push) begin
         if (st_r.head_v) begin
            st_nxt.tail   = bi.data_in;
            st_nxt.tail_v = 1'b1;
         end else begin
            st_nxt.head   = bi.data_in;
            st_nxt.head_v = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   chk_buf_push_order: assert property (@(posedge clk) disable iff (rst) // R6
      (push && !st_r.head_v) |=> (bi.valid_out && bi.data_out == $past(bi.data_in)))
      else $error("buffer lost or reordered a word");
   chk_buf_full_hold: assert property (@(posedge clk) disable iff (rst) // R6
      (st_r.head_v && st_r.tail_v && !bi.ready_out) |=> (!bi.ready_in && bi.valid_out))
      else $error("full buffer did not hold back its source");
   cov_buf_full: cover property (@(posedge clk) disable iff (rst) st_r.tail_v);
endmodule

// ---- src/rtcit_target.sv ----
// I2C target port giving a bus controller access to the clock's registers
module rtcit_target (
   input  wire logic       core_clk,  // Core clock, 100 MHz
   input  wire logic       reset,     // Synchronous reset, high
   input  wire logic       link_clk,  // Link sampling clock
   input  wire logic       scl_i,     // SCL pin level
   output logic            scl_o,     // SCL drive level, always low
   output logic            scl_oe,    // SCL pulled low (stretch)
   input  wire logic       sda_i,     // SDA pin level
   output logic            sda_o,     // SDA drive level, always low
   output logic            sda_oe,    // SDA pulled low
   output logic            wr_valid,  // Register write event waiting
   output logic [7:0]      wr_addr,   // Written register address
   output logic [7:0]      wr_data,   // Written register value
   input  wire logic       wr_ready   // Core takes the write event
);
   //------------------------------------------------------------
   // Link domain state
   //------------------------------------------------------------
   typedef struct packed {
      logic                    scl_s1;
      logic                    scl_s2;
      logic                    scl_d;
      logic                    sda_s1;
      logic                    sda_s2;
      logic                    sda_d;
      logic                    ack_s1;
      logic                    ack_s2;
      rtcit_pkg::rtcit_state_t state;
      rtcit_pkg::rtcit_phase_t phase;
      logic [3:0]              bitcnt;
      logic [7:0]              shreg;
      logic [7:0]              ptr;
      logic                    rw;
      logic                    acked;
      logic                    drv_low;
      logic                    scl_oe;
      logic                    sda_oe;
      logic                    req_tgl;
      rtcit_pkg::rtcit_wr_t    xfer;
   } rtcit_link_t;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic ack_tgl;
   } rtcit_core_t;

   rtcit_link_t ln_r;
   rtcit_link_t ln_nxt;
   rtcit_core_t cr_r;
   rtcit_core_t cr_nxt;
   logic        lrst_s1;
   logic        link_rst;
   logic [7:0]  regs [rtcit_pkg::REG_DEPTH];
   logic [7:0]  rd_byte;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_ev;
   logic        stop_ev;
   logic        busy;
   logic        store;

   rtcit_buf_if bi ();

   //------------------------------------------------------------
   // Reset crossing into the link domain
   //------------------------------------------------------------
   always_ff @(posedge link_clk) begin
      lrst_s1  <= reset;
      link_rst <= lrst_s1;
   end

   //------------------------------------------------------------
   // Bus events
   //------------------------------------------------------------
   assign scl_rise = ln_r.scl_s2 & ~ln_r.scl_d;
   assign scl_fall = ~ln_r.scl_s2 & ln_r.scl_d;
   // SDA edges count only while SCL stays high over both samples
   assign start_ev = ln_r.scl_s2 & ln_r.scl_d & ln_r.sda_d & ~ln_r.sda_s2; // R13
   assign stop_ev  = ln_r.scl_s2 & ln_r.scl_d & ~ln_r.sda_d & ln_r.sda_s2; // R13
   assign busy     = ln_r.req_tgl ^ ln_r.ack_s2;
   assign store    = (ln_r.state == rtcit_pkg::RTCIT_WAIT) & ~busy;
   assign rd_byte  = regs[ln_r.ptr];

   //------------------------------------------------------------
   // Protocol engine
   //------------------------------------------------------------
   always_comb begin
      ln_nxt        = ln_r;
      ln_nxt.scl_s1 = scl_i;
      ln_nxt.scl_s2 = ln_r.scl_s1;
      ln_nxt.scl_d  = ln_r.scl_s2;
      ln_nxt.sda_s1 = sda_i;
      ln_nxt.sda_s2 = ln_r.sda_s1;
      ln_nxt.sda_d  = ln_r.sda_s2;
      ln_nxt.ack_s1 = cr_r.ack_tgl;
      ln_nxt.ack_s2 = ln_r.ack_s1;
      case (ln_r.state)
         rtcit_pkg::RTCIT_IDLE: begin
            ln_nxt.sda_oe = 1'b0; // R2
            ln_nxt.scl_oe = 1'b0;
         end
         rtcit_pkg::RTCIT_RX: begin
            if (scl_rise) begin
               ln_nxt.shreg  = {ln_r.shreg[6:0], ln_r.sda_s2}; // R12
               ln_nxt.bitcnt = ln_r.bitcnt + rtcit_pkg::BIT_STEP;
            end else if (scl_fall && ln_r.bitcnt == rtcit_pkg::RX_BITS) begin // R14
               case (ln_r.phase)
                  rtcit_pkg::RTCIT_PH_ADDR: begin
                     if (ln_r.shreg[7:1] == rtcit_pkg::TGT_ADDR) begin // R1 R3
                        ln_nxt.rw     = ln_r.shreg[0];
                        ln_nxt.sda_oe = 1'b1; // R5 R8
                        ln_nxt.state  = rtcit_pkg::RTCIT_RACK;
                     end else begin
                        ln_nxt.state = rtcit_pkg::RTCIT_IDLE; // R2
                     end
                  end
                  rtcit_pkg::RTCIT_PH_PTR: begin
                     ln_nxt.ptr    = ln_r.shreg;
                     ln_nxt.sda_oe = 1'b1; // R5
                     ln_nxt.state  = rtcit_pkg::RTCIT_RACK;
                  end
                  default: begin
                     // Stretch SCL until the core side can take the byte
                     ln_nxt.scl_oe = 1'b1;
                     ln_nxt.state  = rtcit_pkg::RTCIT_WAIT;
                  end
               endcase
            end
         end
         rtcit_pkg::RTCIT_WAIT: begin
            if (!busy) begin
               ln_nxt.xfer    = '{addr: ln_r.ptr, data: ln_r.shreg}; // R6
               ln_nxt.req_tgl = ~ln_r.req_tgl;
               ln_nxt.ptr     = ln_r.ptr + rtcit_pkg::PTR_STEP; // R6
               // SCL stays held one more cycle so SDA never moves while it is high
               ln_nxt.sda_oe  = 1'b1; // R6 R12
               ln_nxt.state   = rtcit_pkg::RTCIT_RACK;
            end
         end
         rtcit_pkg::RTCIT_RACK: begin
            ln_nxt.scl_oe = 1'b0; // R12
            if (scl_fall) begin
               ln_nxt.bitcnt = '0;
               if (ln_r.phase == rtcit_pkg::RTCIT_PH_ADDR && ln_r.rw == rtcit_pkg::RW_READ) begin
                  // Pointer holds the written pointer after a repeated START, else last access plus one
                  ln_nxt.shreg  = rd_byte; // R9 R11
                  ln_nxt.sda_oe = ~rd_byte[7]; // R12
                  ln_nxt.phase  = rtcit_pkg::RTCIT_PH_READ;
                  ln_nxt.state  = rtcit_pkg::RTCIT_TX;
               end else begin
                  ln_nxt.sda_oe = 1'b0;
                  ln_nxt.state  = rtcit_pkg::RTCIT_RX;
                  if (ln_r.phase == rtcit_pkg::RTCIT_PH_ADDR) begin
                     ln_nxt.phase = rtcit_pkg::RTCIT_PH_PTR;
                  end else begin
                     ln_nxt.phase = rtcit_pkg::RTCIT_PH_DATA;
                  end
               end
            end
         end
         rtcit_pkg::RTCIT_TX: begin
            if (scl_fall) begin
               if (ln_r.bitcnt == rtcit_pkg::TX_LAST) begin
                  ln_nxt.sda_oe = 1'b0;
                  ln_nxt.ptr    = ln_r.ptr + rtcit_pkg::PTR_STEP; // R9 R11
                  ln_nxt.state  = rtcit_pkg::RTCIT_TACK;
               end else begin
                  ln_nxt.shreg  = {ln_r.shreg[6:0], 1'b0};
                  ln_nxt.sda_oe = ~ln_r.shreg[6]; // R12
                  ln_nxt.bitcnt = ln_r.bitcnt + rtcit_pkg::BIT_STEP;
               end
            end
         end
         rtcit_pkg::RTCIT_TACK: begin
            if (scl_rise) begin
               ln_nxt.acked = ~ln_r.sda_s2;
            end else if (scl_fall) begin
               if (ln_r.acked) begin
                  ln_nxt.shreg  = rd_byte; // R9
                  ln_nxt.sda_oe = ~rd_byte[7];
                  ln_nxt.bitcnt = '0;
                  ln_nxt.state  = rtcit_pkg::RTCIT_TX;
               end else begin
                  ln_nxt.state = rtcit_pkg::RTCIT_IDLE; // R10
               end
            end
         end
         default: begin
            ln_nxt.state = rtcit_pkg::RTCIT_IDLE;
         end
      endcase
      // A repeated START restarts exactly like a first START
      if (start_ev) begin
         ln_nxt.state  = rtcit_pkg::RTCIT_RX; // R13 R8
         ln_nxt.phase  = rtcit_pkg::RTCIT_PH_ADDR;
         ln_nxt.bitcnt = '0;
         ln_nxt.sda_oe = 1'b0;
         ln_nxt.scl_oe = 1'b0;
      end else if (stop_ev) begin
         // A partial byte before STOP is dropped
         ln_nxt.state  = rtcit_pkg::RTCIT_IDLE; // R10 R14
         ln_nxt.sda_oe = 1'b0;
         ln_nxt.scl_oe = 1'b0;
      end
   end

   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         ln_r <= '0;
      end else begin
         ln_r <= ln_nxt;
      end
   end

   // Register contents have no reset; they belong to the clock core
   always_ff @(posedge link_clk) begin
      if (store) begin
         regs[ln_r.ptr] <= ln_r.shreg; // R6
      end
   end

   // Open-drain: only the enables move, the level stays low
   assign scl_o  = ln_r.drv_low; // R4
   assign sda_o  = ln_r.drv_low; // R4
   assign scl_oe = ln_r.scl_oe;
   assign sda_oe = ln_r.sda_oe;

   //------------------------------------------------------------
   // Core domain: toggle handshake into the buffer
   //------------------------------------------------------------
   always_comb begin
      cr_nxt        = cr_r;
      cr_nxt.req_s1 = ln_r.req_tgl;
      cr_nxt.req_s2 = cr_r.req_s1;
      if ((cr_r.req_s2 != cr_r.ack_tgl) && bi.ready_in) begin
         cr_nxt.ack_tgl = cr_r.req_s2;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cr_r <= '0;
      end else begin
         cr_r <= cr_nxt;
      end
   end

   // Word stays still while the toggle is outstanding
   assign bi.valid_in  = cr_r.req_s2 ^ cr_r.ack_tgl;
   assign bi.data_in   = ln_r.xfer;
   assign bi.ready_out = wr_ready;
   assign wr_valid     = bi.valid_out;
   assign wr_addr      = bi.data_out.addr;
   assign wr_data      = bi.data_out.data;

   rtcit_buf u_buf (
      .clk (core_clk),
      .rst (reset),
      .bi  (bi.fifo)
   );

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   chk_idle_sda_free: assert property (@(posedge link_clk) disable iff (link_rst) // R2
      (ln_r.state == rtcit_pkg::RTCIT_IDLE && !start_ev) |=> !sda_oe)
      else $error("SDA driven outside a selected transfer");
   chk_start_restart: assert property (@(posedge link_clk) disable iff (link_rst) // R13
      start_ev |=> (ln_r.state == rtcit_pkg::RTCIT_RX && ln_r.bitcnt == '0
                    && ln_r.phase == rtcit_pkg::RTCIT_PH_ADDR))
      else $error("START did not restart address reception");
   chk_stop_release: assert property (@(posedge link_clk) disable iff (link_rst) // R10
      stop_ev |=> (ln_r.state == rtcit_pkg::RTCIT_IDLE && !sda_oe && !scl_oe))
      else $error("STOP did not release the bus");
   chk_addr_ack: assert property (@(posedge link_clk) disable iff (link_rst) // R5
      (ln_r.state == rtcit_pkg::RTCIT_RX && scl_fall && !start_ev && !stop_ev
       && ln_r.bitcnt == rtcit_pkg::RX_BITS && ln_r.phase == rtcit_pkg::RTCIT_PH_ADDR)
      |=> (sda_oe == ($past(ln_r.shreg[7:1]) == rtcit_pkg::TGT_ADDR)))
      else $error("address acknowledge does not match own address");
   chk_tx_msb_first: assert property (@(posedge link_clk) disable iff (link_rst) // R12
      (ln_r.state == rtcit_pkg::RTCIT_TX) |-> (sda_oe == !ln_r.shreg[7]))
      else $error("transmitted bit is not the byte's top bit");
   chk_ptr_advance: assert property (@(posedge link_clk) disable iff (link_rst) // R9
      (ln_r.state == rtcit_pkg::RTCIT_TX && scl_fall && !start_ev && !stop_ev
       && ln_r.bitcnt == rtcit_pkg::TX_LAST)
      |=> (ln_r.ptr == $past(ln_r.ptr) + rtcit_pkg::PTR_STEP
           && ln_r.state == rtcit_pkg::RTCIT_TACK))
      else $error("pointer did not advance after a sent byte");
   chk_store_ack: assert property (@(posedge link_clk) disable iff (link_rst) // R6
      (store && !start_ev && !stop_ev) |=> (sda_oe && busy
         && ln_r.ptr == $past(ln_r.ptr) + rtcit_pkg::PTR_STEP)
      ##1 (ln_r.state == rtcit_pkg::RTCIT_RACK || start_ev || stop_ev))
      else $error("stored byte not acknowledged or pointer not advanced");
   chk_nack_ends: assert property (@(posedge link_clk) disable iff (link_rst) // R10
      (ln_r.state == rtcit_pkg::RTCIT_TACK && scl_fall && !ln_r.acked && !start_ev)
      |=> (ln_r.state == rtcit_pkg::RTCIT_IDLE) [*2])
      else $error("read continued after a high acknowledge");
   chk_xfer_taken: assert property (@(posedge core_clk) disable iff (reset) // R6
      (bi.valid_in && bi.ready_in) |=> (!bi.valid_in && bi.valid_out))
      else $error("crossed write was not handed to the buffer");

   cov_write_byte: cover property (@(posedge link_clk) disable iff (link_rst) store);
   cov_read_ack: cover property (@(posedge link_clk) disable iff (link_rst)
      ln_r.state == rtcit_pkg::RTCIT_TACK && scl_fall && ln_r.acked);
   cov_stretch: cover property (@(posedge link_clk) disable iff (link_rst)
      ln_r.state == rtcit_pkg::RTCIT_WAIT && busy);
endmodule

// ---- bench/rtcit_host.sv ----
// Bus controller model driving the target over open-drain SCL and SDA
module rtcit_host (
   input  wire logic link_clk, // Link clock
   input  wire logic scl,      // SCL wire level
   input  wire logic sda,      // SDA wire level
   output logic      scl_dn,   // Pull SCL low
   output logic      sda_dn    // Pull SDA low
);
   timeunit 1ns;
   timeprecision 1ps;

   //------------------------------------------------------------------
   // Line phases
   //------------------------------------------------------------------
   initial begin
      scl_dn = 1'b0;
      sda_dn = 1'b0;
   end

   // Eight link cycles per phase, above the six the target needs
   task automatic hold();
      repeat (8) @(posedge link_clk);
   endtask

   // Bounded wait, since the target may stretch SCL low
   task automatic scl_up();
      int n = 0;
      scl_dn <= 1'b0;
      while (scl !== 1'b1 && n < 4000) begin
         @(posedge link_clk);
         n++;
      end
      hold();
   endtask

   // Also serves as a repeated start
   task automatic start();
      sda_dn <= 1'b0;
      hold();
      scl_up();
      sda_dn <= 1'b1;
      hold();
      scl_dn <= 1'b1;
      hold();
   endtask

   // Ends every transaction well within its time limit
   task automatic stop();
      sda_dn <= 1'b1;
      hold();
      scl_up();
      sda_dn <= 1'b0;
      hold();
   endtask

   // One clock with SDA set while SCL is low
   task automatic send_bit(input logic b);
      sda_dn <= ~b;
      hold();
      scl_up();
      scl_dn <= 1'b1;
      hold();
   endtask

   // Whole byte, high bit first, then the ninth clock for the acknowledge
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i]);
      end
      sda_dn <= 1'b0;
      hold();
      scl_up();
      ack = (sda === 1'b0);
      scl_dn <= 1'b1;
      hold();
   endtask

   // Receive one byte; a high acknowledge marks the last one
   task automatic recv_byte(input logic last, output logic [7:0] b);
      sda_dn <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         hold();
         scl_up();
         b[i] = sda;
         scl_dn <= 1'b1;
      end
      // Let SCL settle low before the acknowledge moves SDA
      hold();
      send_bit(last);
   endtask
endmodule

// ---- bench/rtcit_target_tb_top.sv ----
// Testbench top of the I2C target register port
module rtcit_target_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int CYC_LIMIT = 80000;

   logic        core_clk;
   logic        reset;
   logic        link_clk;
   logic        scl_o;
   logic        scl_oe;
   logic        sda_o;
   logic        sda_oe;
   logic        wr_valid;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_data;
   logic        wr_ready;
   logic        take_en;
   logic        scl_dn;
   logic        sda_dn;
   wire logic   scl;
   wire logic   sda;
   logic [15:0] got_q[$];
   int          num_errors = 0;
   int          num_checks = 0;
   int          cyc = 0;

   // Pull-ups make a released line read high
   assign scl = ~(scl_oe | scl_dn);
   assign sda = ~(sda_oe | sda_dn);

   rtcit_target u_dut (
      .core_clk (core_clk),
      .reset    (reset),
      .link_clk (link_clk),
      .scl_i    (scl),
      .scl_o    (scl_o),
      .scl_oe   (scl_oe),
      .sda_i    (sda),
      .sda_o    (sda_o),
      .sda_oe   (sda_oe),
      .wr_valid (wr_valid),
      .wr_addr  (wr_addr),
      .wr_data  (wr_data),
      .wr_ready (wr_ready)
   );

   rtcit_host u_host (
      .link_clk (link_clk),
      .scl      (scl),
      .sda      (sda),
      .scl_dn   (scl_dn),
      .sda_dn   (sda_dn)
   );

   //------------------------------------------------------------------
   // Clocks, core-side sink and watchdog
   //------------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Odd offset, yet link and core rising edges still meet every 240 ns, first at 175 ns
   initial begin
      link_clk = 1'b0;
      #7;
      forever #24 link_clk = ~link_clk;
   end

   always @(posedge core_clk) begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
         got_q.push_back({wr_addr, wr_data});
      end
      wr_ready <= take_en;
      cyc++;
      if (cyc == CYC_LIMIT) begin
         num_errors++;
         end_of_test();
      end
   end

   //------------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tx(input logic [7:0] b, input logic ack_exp);
      logic ak;
      u_host.send_byte(b, ak);
      check("acknowledge", {15'h0000, ak}, {15'h0000, ack_exp});
   endtask

   task automatic rx(input logic last, input logic [7:0] exp);
      logic [7:0] b;
      u_host.recv_byte(last, b);
      check("read byte", {8'h00, b}, {8'h00, exp});
   endtask

   task automatic wait_words(input int n);
      int k = 0;
      while (got_q.size() < n && k < 400) begin
         @(posedge core_clk);
         k++;
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   //------------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------------
   task automatic t_write();
      got_q.delete();
      u_host.start();
      tx(8'h64, 1'b1);
      tx(8'h10, 1'b1);
      for (int i = 0; i < 4; i++) begin
         tx(8'ha1 + 8'(i), 1'b1);
      end
      u_host.stop();
      wait_words(4);
      check("word count", 16'(got_q.size()), 16'h0004);
      for (int i = 0; i < 4; i++) begin
         check("stored word", got_q[i], {8'h10 + 8'(i), 8'ha1 + 8'(i)});
      end
      $display("test write done");
   endtask

   task automatic t_read();
      got_q.delete();
      u_host.start();
      tx(8'h64, 1'b1);
      tx(8'h10, 1'b1);
      u_host.start();
      tx(8'h65, 1'b1);
      rx(1'b0, 8'ha1);
      rx(1'b0, 8'ha2);
      rx(1'b1, 8'ha3);
      check("sda after last", {15'h0000, sda_oe}, 16'h0000);
      u_host.stop();
      check("pointer write stores", 16'(got_q.size()), 16'h0000);
      u_host.start();
      tx(8'h65, 1'b1);
      rx(1'b1, 8'ha4);
      u_host.stop();
      $display("test read done");
   endtask

   task automatic t_foreign();
      got_q.delete();
      u_host.start();
      tx(8'h66, 1'b0);
      tx(8'h55, 1'b0);
      u_host.stop();
      u_host.start();
      tx(8'h67, 1'b0);
      u_host.stop();
      wait_words(1);
      check("foreign stores", 16'(got_q.size()), 16'h0000);
      $display("test foreign done");
   endtask

   // Core stalls: two words buffer, one waits in the crossing, the fourth holds SCL low
   task automatic t_stall();
      int run = 0;
      int k = 0;
      got_q.delete();
      take_en = 1'b0;
      u_host.start();
      tx(8'h64, 1'b1);
      tx(8'h20, 1'b1);
      fork
         begin
            for (int i = 0; i < 4; i++) begin
               tx(8'hb1 + 8'(i), 1'b1);
            end
            u_host.stop();
         end
         begin
            while (run < 100 && k < 4000) begin
               @(posedge link_clk);
               run = (scl_oe === 1'b1) ? run + 1 : 0;
               k++;
            end
            check("stretch held", 16'(run), 16'h0064);
            check("word stands", {wr_valid, 7'h00, wr_addr}, 16'h8020);
            take_en = 1'b1;
         end
      join
      wait_words(4);
      check("drained count", 16'(got_q.size()), 16'h0004);
      for (int i = 0; i < 4; i++) begin
         check("drained word", got_q[i], {8'h20 + 8'(i), 8'hb1 + 8'(i)});
      end
      $display("test stall done");
   endtask

   //------------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------------
   // Reset spans four link cycles so the link side sees it too
   initial begin
      reset = 1'b1;
      take_en = 1'b1;
      repeat (4) @(posedge link_clk);
      @(posedge core_clk);
      reset <= 1'b0;
      repeat (4) @(posedge link_clk);
      check("idle lines", {14'h0000, scl_oe, sda_oe}, 16'h0000);
      check("drive levels", {14'h0000, scl_o, sda_o}, 16'h0000);
      t_write();
      t_read();
      t_foreign();
      t_stall();
      end_of_test();
   end
endmodule
